// [rtl/tv_pkg.sv]
package tv_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CDB_LO = 8'h00;
	localparam logic [7:0] ADDR_CDB_HI = 8'h04;
	localparam logic [7:0] ADDR_CTRL = 8'h08;
	localparam logic [7:0] ADDR_CFG = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_SENSE = 8'h14;
	localparam logic [7:0] ADDR_INFO = 8'h18;
	localparam logic [7:0] ADDR_COUNT = 8'h1C;
	// Field positions
	localparam int CTRL_START_BIT = 0;
	localparam int CFG_ND_BIT = 24;
	localparam int FLAG_FIXED_BIT = 0;
	localparam int FLAG_BYTE_COMPARE_FLAG_BIT = 1;
	localparam int FLAG_IMMED_BIT = 2;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_CHECK_BIT = 2;
	localparam int STAT_DEFER_BIT = 3;
	localparam int STAT_DATA_BIT = 4;
	// Reset values
	localparam logic [23:0] BLK_LEN_RESET = 24'h000000;
	localparam logic [31:0] CDB_RESET = 32'h00000000;
	// Opcodes
	localparam logic [7:0] OP_UNIT_READY = 8'h00;
	localparam logic [7:0] OP_VERIFY = 8'h13;
	// Sense keys and additional codes
	localparam logic [3:0] KEY_NO_SENSE = 4'h0;
	localparam logic [3:0] KEY_NOT_READY = 4'h2;
	localparam logic [3:0] KEY_MEDIUM = 4'h3;
	localparam logic [3:0] KEY_HARDWARE = 4'h4;
	localparam logic [3:0] KEY_ILLEGAL = 4'h5;
	localparam logic [3:0] KEY_BLANK = 4'h8;
	localparam logic [7:0] ASC_FIX_VAR = 8'h81;
	localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
	localparam logic [7:0] ASC_BAD_OPCODE = 8'h20;
	localparam logic [7:0] ASCQ_ZERO = 8'h00;
	// Variable block limits in bytes
	localparam logic [23:0] LIMIT_NORMAL = 24'h03C000;
	localparam logic [23:0] LIMIT_NO_DISC = 24'h028000;
	// Media engine results and command states
	typedef enum logic [2:0] {
		RES_OK = 3'b000,
		RES_FILEMARK = 3'b001,
		RES_BLANK = 3'b010,
		RES_TAPE_END = 3'b011,
		RES_MEDIA_ERR = 3'b100,
		RES_HW_ERR = 3'b101
	} tv_result_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CHECK = 3'b001,
		ST_REQ = 3'b010,
		ST_WAIT = 3'b011,
		ST_DONE = 3'b100
	} tv_state_t;
endpackage

// [rtl/tv_axil.sv]
`timescale 1ns/1ps
module tv_axil (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, low
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte enables
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic [31:0] rd_data, // Decoded read word for araddr
	input wire logic rd_ok, // Read address is mapped
	output logic wr_en, // One-cycle write pulse
	output logic [7:0] wr_addr, // Write address
	output logic [31:0] wr_data, // Write data
	output logic [3:0] wr_strb // Write byte enables
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [7:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
		logic wr;
	} tv_axil_t;
	tv_axil_t q, d;

	always_comb begin
		d = q;
		d.wr = 1'b0;
		if (s_axi_awvalid && q.awready) begin
			d.addr = s_axi_awaddr;
			d.awready = 1'b0;
		end
		if (s_axi_wvalid && q.wready) begin
			d.data = s_axi_wdata;
			d.strb = s_axi_wstrb;
			d.wready = 1'b0;
		end
		// Both halves held and no answer pending: commit once
		if (!d.awready && !d.wready && !q.bvalid && !q.wr) begin
			d.wr = 1'b1;
			d.bvalid = 1'b1;
			d.bresp = 2'b00;
		end
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
			d.awready = 1'b1;
			d.wready = 1'b1;
		end
		if (s_axi_arvalid && q.arready) begin
			d.arready = 1'b0;
			d.rvalid = 1'b1;
			d.rdata = rd_ok ? rd_data : 32'h00000000;
			d.rresp = rd_ok ? 2'b00 : 2'b10;
		end else if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
			d.arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
		end else begin
			q <= d;
		end
	end

	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rdata = q.rdata;
	assign wr_en = q.wr;
	assign wr_addr = q.addr;
	assign wr_data = q.data;
	assign wr_strb = q.strb;
endmodule

// [rtl/tv_sense.sv]
`timescale 1ns/1ps
module tv_sense (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, low
	input wire logic clear, // New command: drop old sense
	input wire logic load, // Capture new sense
	input wire logic [3:0] key_in, // Sense key
	input wire logic fm_in, // Filemark flag
	input wire logic eom_in, // End of medium flag
	input wire logic ili_in, // Length mismatch flag
	input wire logic valid_in, // Information valid flag
	input wire logic physical_tape_end_in, // Physical tape end flag
	input wire logic [7:0] asc_in, // Additional code
	input wire logic [7:0] ascq_in, // Additional qualifier
	input wire logic [31:0] info_in, // Information field
	output logic [31:0] sense_word, // Packed key, flags, codes
	output logic [31:0] info_word // Held information field
);
	typedef struct packed {
		logic [3:0] key;
		logic fm;
		logic end_of_medium_flag;
		logic length_mismatch_flag;
		logic valid;
		logic physical_tape_end;
		logic [7:0] asc;
		logic [7:0] ascq;
		logic [31:0] info;
	} tv_sense_t;
	tv_sense_t q, d;

	always_comb begin
		d = q;
		if (load) begin
			d = {key_in, fm_in, eom_in, ili_in, valid_in, physical_tape_end_in, asc_in, ascq_in, info_in}; // RQ21
		end else if (clear) begin
			d = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sense_word = {q.ascq, q.asc, 6'h00, q.physical_tape_end, q.valid, q.fm, q.end_of_medium_flag, q.length_mismatch_flag, 1'b0, q.key};
	assign info_word = q.info;
endmodule

// [rtl/tv_cmd.sv]
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
// How it works
// RQ1: Unit-ready: Good if ready, else Not Ready
// RQ2: Unit-ready only reports, never self-tests
// RQ3: Verify from next block, end past last
// RQ4: Immediate flag posts status at start
// RQ5: Initiator keeps byte-compare flag zero
// RQ6: Fixed flag: block count versus byte length
// RQ7: Fixed/variable mismatch rejected, codes 81h/00h
// RQ8: Variable length within 240K or 160K
// RQ9: Zero length verifies nothing, no motion
// RQ10: Filemark ends with filemark, valid, No Sense
// RQ11: Blank tape ends with Blank Check
// RQ12: Tape end reports medium error, end flags
// RQ13: Unrecoverable error: medium or hardware key
// RQ14: Error may follow an entered data phase
// RQ15: Variable mismatch: info is requested minus actual
// RQ16: Fixed mismatch: info counts unverified blocks
// RQ17: Mismatch leaves tape past the bad block
// RQ18: Vendor bits of last byte ignored
// RQ19: Blank Check key is 8h
// RQ20: No Sense key is 0h
// RQ21: Sense held for later sense request
module tv_cmd (
	input wire logic aclk, // Clock, 200 MHz
	input wire logic aresetn, // Sync reset, low
	input wire logic [7:0] s_axi_awaddr, // AXI write address
	input wire logic [2:0] s_axi_awprot, // AXI protection, unused
	input wire logic s_axi_awvalid, // AXI write address valid
	output logic s_axi_awready, // AXI write address ready
	input wire logic [31:0] s_axi_wdata, // AXI write data
	input wire logic [3:0] s_axi_wstrb, // AXI byte enables
	input wire logic s_axi_wvalid, // AXI write data valid
	output logic s_axi_wready, // AXI write data ready
	output logic [1:0] s_axi_bresp, // AXI write response
	output logic s_axi_bvalid, // AXI write response valid
	input wire logic s_axi_bready, // AXI write response ready
	input wire logic [7:0] s_axi_araddr, // AXI read address
	input wire logic [2:0] s_axi_arprot, // AXI protection, unused
	input wire logic s_axi_arvalid, // AXI read address valid
	output logic s_axi_arready, // AXI read address ready
	output logic [31:0] s_axi_rdata, // AXI read data
	output logic [1:0] s_axi_rresp, // AXI read response
	output logic s_axi_rvalid, // AXI read data valid
	input wire logic s_axi_rready, // AXI read data ready
	input wire logic media_ready, // Drive can take media access
	output logic mv_req, // Pulse: verify next block
	output logic [23:0] mv_len, // Expected block length
	input wire logic mv_done, // Pulse: block outcome ready
	input wire logic [2:0] mv_result, // Outcome code
	input wire logic [23:0] mv_actual, // Recorded block length
	output logic data_phase // Verify has moved data
);
	typedef struct packed {
		tv_pkg::tv_state_t st;
		logic [31:0] cdb_lo;
		logic [15:0] cdb_hi;
		logic [23:0] blk_len;
		logic nd;
		logic start;
		logic [23:0] remain;
		logic [23:0] verified;
		logic [23:0] expect_len;
		logic mv_req;
		logic data_phase;
		logic busy;
		logic done;
		logic check;
		logic deferred;
		logic immed;
	} tv_cmd_t;
	tv_cmd_t q, d;

	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [31:0] rd_data;
	logic rd_ok;
	logic [31:0] sense_word;
	logic [31:0] info_word;
	logic sns_clear;
	logic sns_load;
	logic [3:0] sns_key;
	logic sns_fm;
	logic sns_eom;
	logic sns_ili;
	logic sns_valid;
	logic sns_physical_tape_end;
	logic [7:0] sns_asc;
	logic [7:0] sns_ascq;
	logic [31:0] sns_info;

	wire logic [7:0] opcode = q.cdb_lo[7:0];
	wire logic [7:0] flags = q.cdb_lo[15:8];
	// Vendor bits of byte 5 are stored but never decoded
	wire logic [23:0] req_len = {q.cdb_lo[23:16], q.cdb_lo[31:24], q.cdb_hi[7:0]}; // RQ18
	wire logic fixed = flags[tv_pkg::FLAG_FIXED_BIT];
	wire logic [23:0] var_limit = q.nd ? tv_pkg::LIMIT_NO_DISC : tv_pkg::LIMIT_NORMAL;
	wire logic [24:0] len_diff = {1'b0, req_len} - {1'b0, mv_actual};
	// Fixed mode counts blocks left; variable mode reports the request
	wire logic [31:0] info_count = fixed ? {8'h00, q.remain} : {8'h00, req_len};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	tv_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rd_data(rd_data),
		.rd_ok(rd_ok),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb)
	);

	tv_sense u_sense (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(sns_clear),
		.load(sns_load),
		.key_in(sns_key),
		.fm_in(sns_fm),
		.eom_in(sns_eom),
		.ili_in(sns_ili),
		.valid_in(sns_valid),
		.physical_tape_end_in(sns_physical_tape_end),
		.asc_in(sns_asc),
		.ascq_in(sns_ascq),
		.info_in(sns_info),
		.sense_word(sense_word),
		.info_word(info_word)
	);

	always_comb begin
		rd_ok = 1'b1;
		if (s_axi_araddr == tv_pkg::ADDR_CDB_LO) begin
			rd_data = q.cdb_lo;
		end else if (s_axi_araddr == tv_pkg::ADDR_CDB_HI) begin
			rd_data = {16'h0000, q.cdb_hi};
		end else if (s_axi_araddr == tv_pkg::ADDR_CTRL) begin
			rd_data = 32'h00000000;
		end else if (s_axi_araddr == tv_pkg::ADDR_CFG) begin
			rd_data = {7'h00, q.nd, q.blk_len};
		end else if (s_axi_araddr == tv_pkg::ADDR_STATUS) begin
			rd_data = {27'h0000000, q.data_phase, q.deferred, q.check, q.done, q.busy};
		end else if (s_axi_araddr == tv_pkg::ADDR_SENSE) begin
			rd_data = sense_word; // RQ21
		end else if (s_axi_araddr == tv_pkg::ADDR_INFO) begin
			rd_data = info_word; // RQ21
		end else if (s_axi_araddr == tv_pkg::ADDR_COUNT) begin
			rd_data = {8'h00, q.verified};
		end else begin
			rd_data = 32'h00000000;
			rd_ok = 1'b0;
		end
	end

	always_comb begin
		d = q;
		d.mv_req = 1'b0;
		d.start = 1'b0;
		sns_clear = 1'b0;
		sns_load = 1'b0;
		sns_key = tv_pkg::KEY_NO_SENSE;
		sns_fm = 1'b0;
		sns_eom = 1'b0;
		sns_ili = 1'b0;
		sns_valid = 1'b0;
		sns_physical_tape_end = 1'b0;
		sns_asc = tv_pkg::ASCQ_ZERO;
		sns_ascq = tv_pkg::ASCQ_ZERO;
		sns_info = 32'h00000000;
		// Command and config are frozen while a command runs
		if (wr_en && !q.busy) begin
			if (wr_addr == tv_pkg::ADDR_CDB_LO) begin
				d.cdb_lo = merge(q.cdb_lo, wr_data, wr_strb);
			end else if (wr_addr == tv_pkg::ADDR_CDB_HI) begin
				d.cdb_hi = 16'(merge({16'h0000, q.cdb_hi}, wr_data, wr_strb));
			end else if (wr_addr == tv_pkg::ADDR_CTRL) begin
				d.start = wr_strb[0] & wr_data[tv_pkg::CTRL_START_BIT];
			end else if (wr_addr == tv_pkg::ADDR_CFG) begin
				d.blk_len = 24'(merge({8'h00, q.blk_len}, wr_data, wr_strb));
				if (wr_strb[3]) begin
					d.nd = wr_data[tv_pkg::CFG_ND_BIT];
				end
			end
		end
		case (q.st)
			tv_pkg::ST_IDLE: begin
				if (q.start) begin
					d.st = tv_pkg::ST_CHECK;
					d.busy = 1'b1;
					d.done = 1'b0;
					d.check = 1'b0;
					d.deferred = 1'b0;
					d.data_phase = 1'b0;
					d.verified = 24'h000000;
					d.immed = 1'b0;
					sns_clear = 1'b1;
				end
			end
			tv_pkg::ST_CHECK: begin
				d.st = tv_pkg::ST_DONE;
				sns_load = 1'b1;
				if (opcode == tv_pkg::OP_UNIT_READY) begin
					// Readiness is only reported; nothing is started
					if (!media_ready) begin // RQ1 RQ2
						d.check = 1'b1;
						sns_key = tv_pkg::KEY_NOT_READY; // RQ1
					end
				end else if (opcode == tv_pkg::OP_VERIFY) begin
					if (!media_ready) begin
						d.check = 1'b1;
						sns_key = tv_pkg::KEY_NOT_READY;
					end else if (fixed == (q.blk_len == 24'h000000)) begin // RQ7
						d.check = 1'b1;
						sns_key = tv_pkg::KEY_ILLEGAL; // RQ7
						sns_asc = tv_pkg::ASC_FIX_VAR; // RQ7
					end else if (!fixed && req_len > var_limit) begin // RQ8
						d.check = 1'b1;
						sns_key = tv_pkg::KEY_ILLEGAL;
						sns_asc = tv_pkg::ASC_BAD_FIELD;
					end else if (req_len != 24'h000000) begin // RQ9
						sns_load = 1'b0;
						d.st = tv_pkg::ST_REQ;
						d.remain = fixed ? req_len : 24'h000001; // RQ6
						d.expect_len = fixed ? q.blk_len : req_len; // RQ6
						if (flags[tv_pkg::FLAG_IMMED_BIT]) begin // RQ4
							d.immed = 1'b1;
							d.done = 1'b1;
						end
					end
				end else begin
					d.check = 1'b1;
					sns_key = tv_pkg::KEY_ILLEGAL;
					sns_asc = tv_pkg::ASC_BAD_OPCODE;
				end
			end
			tv_pkg::ST_REQ: begin
				d.mv_req = 1'b1; // RQ3
				d.st = tv_pkg::ST_WAIT;
			end
			tv_pkg::ST_WAIT: begin
				if (mv_done) begin
					d.data_phase = 1'b1; // RQ14
					d.st = tv_pkg::ST_DONE;
					sns_load = 1'b1;
					sns_valid = 1'b1;
					sns_info = info_count;
					case (mv_result)
						tv_pkg::RES_OK: begin
							if (mv_actual != q.expect_len) begin // RQ15 RQ16
								// Engine has already moved past the bad block
								sns_ili = 1'b1; // RQ17
								sns_key = tv_pkg::KEY_NO_SENSE; // RQ20
								sns_info = fixed ? {8'h00, q.remain} : {{7{len_diff[24]}}, len_diff}; // RQ15 RQ16
							end else begin
								sns_load = 1'b0;
								d.verified = q.verified + 24'h000001;
								d.remain = q.remain - 24'h000001;
								d.st = (q.remain == 24'h000001) ? tv_pkg::ST_DONE : tv_pkg::ST_REQ; // RQ3
							end
						end
						tv_pkg::RES_FILEMARK: begin
							sns_fm = 1'b1; // RQ10
							sns_key = tv_pkg::KEY_NO_SENSE; // RQ20
						end
						tv_pkg::RES_BLANK: begin
							sns_key = tv_pkg::KEY_BLANK; // RQ11 RQ19
						end
						tv_pkg::RES_TAPE_END: begin
							sns_eom = 1'b1; // RQ12
							sns_physical_tape_end = 1'b1;
							sns_key = tv_pkg::KEY_MEDIUM;
						end
						tv_pkg::RES_MEDIA_ERR: begin
							sns_key = tv_pkg::KEY_MEDIUM; // RQ13
						end
						default: begin
							sns_key = tv_pkg::KEY_HARDWARE; // RQ13
						end
					endcase
					if (sns_load) begin
						// Status already posted early: error waits as deferred
						d.check = !q.immed;
						d.deferred = q.immed; // RQ4 RQ14
					end
				end
			end
			tv_pkg::ST_DONE: begin
				d.st = tv_pkg::ST_IDLE;
				d.busy = 1'b0;
				d.done = 1'b1;
			end
			default: begin
				d.st = tv_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.cdb_lo <= tv_pkg::CDB_RESET;
			q.blk_len <= tv_pkg::BLK_LEN_RESET;
		end else begin
			q <= d;
		end
	end

	assign mv_req = q.mv_req;
	assign mv_len = q.expect_len;
	assign data_phase = q.data_phase;
endmodule

// [tb/tv_cmd_props.sv]
`timescale 1ns/1ps
module tv_cmd_props (
	input logic aclk, // Clock
	input logic aresetn, // Sync reset, low
	input logic s_axi_awvalid, // Write address valid
	input logic s_axi_awready, // Write address ready
	input logic s_axi_wvalid, // Write data valid
	input logic s_axi_wready, // Write data ready
	input logic [1:0] s_axi_bresp, // Write response
	input logic s_axi_bvalid, // Write response valid
	input logic s_axi_arvalid, // Read address valid
	input logic s_axi_arready, // Read address ready
	input logic s_axi_rvalid, // Read data valid
	input logic mv_req, // Block request
	input logic [23:0] mv_len, // Expected length
	input logic mv_done, // Block outcome
	input logic data_phase // Data moved
);
	logic wait_q;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			wait_q <= 1'b0;
		else if (mv_req)
			wait_q <= 1'b1;
		else if (mv_done)
			wait_q <= 1'b0;
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	wr_latency_a: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
		|=> s_axi_bvalid) else $error("write answer not one cycle after request");
	bresp_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00) else $error("write answer not okay");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answer pending");
	req_pulse_a: assert property (mv_req |=> !mv_req) else $error("block request wider than one cycle");
	req_single_a: assert property (wait_q && !mv_done |-> !mv_req)
		else $error("second block request before outcome");
	len_stable_a: assert property (wait_q |-> $stable(mv_len)) else $error("length moved while waiting");
	dphase_set_a: assert property (mv_done |=> data_phase) else $error("data phase not set by outcome");
	dphase_rise_a: assert property ($rose(data_phase) |-> $past(mv_done))
		else $error("data phase rose without outcome");
endmodule

// [tb/tv_media_model.sv]
`timescale 1ns/1ps
module tv_media_model (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Sync reset, low
	input wire logic mv_req, // Block request
	input wire logic [23:0] mv_len, // Expected length
	output logic mv_done, // Outcome strobe
	output logic [2:0] mv_result, // Outcome code
	output logic [23:0] mv_actual, // Recorded length
	input wire logic [31:0] fail_at, // Failing block index
	input wire logic [2:0] fail_res, // Failure code, ok means bad length
	input wire logic [23:0] bad_len, // Wrong recorded length
	input wire logic [31:0] lat, // Reply delay
	output int n_req, // Requests seen
	output logic [23:0] seen_len // Last requested length
);
	int left = 0;
	int idx = 0;
	initial begin
		mv_done = 1'b0;
		mv_result = 3'h0;
		mv_actual = 24'h0;
		n_req = 0;
		seen_len = 24'h0;
	end
	always @(posedge aclk) begin
		mv_done <= 1'b0;
		// Outcome lines toggle between strobes so stale values never look valid
		mv_result <= ~mv_result;
		mv_actual <= ~mv_actual;
		if (!aresetn) begin
			left = 0;
			n_req <= 0;
		end else begin
			if (left == 1) begin
				mv_done <= 1'b1;
				mv_result <= (idx == fail_at && fail_res != 3'h0) ? fail_res : tv_pkg::RES_OK;
				mv_actual <= (idx == fail_at && fail_res == 3'h0) ? bad_len : mv_len;
			end
			if (left > 0)
				left = left - 1;
			if (mv_req) begin
				left = int'(lat) + 1;
				idx = n_req;
				n_req <= n_req + 1;
				seen_len <= mv_len;
			end
		end
	end
endmodule

// [tb/tv_cmd_test.sv]
`timescale 1ns/1ps
module tv_cmd_test;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mv_req, mv_done, data_phase;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [31:0] s_axi_rdata, rd, st, sns, inf, cnt, fail_at = 32'hFFFFFFFF, lat = 32'h1;
	logic [23:0] mv_len, mv_actual, seen_len, n, blk, bad, bad_len = 24'h0;
	logic [2:0] mv_result, fail_res = 3'h0;
	logic media_ready = 1'b1;
	logic fixed, imm, nd, fails, early;
	int n_req, k, blocks, base, r;
	int n_mismatch = 0, checks_done = 0, seed = 32'haeb75062;
	localparam logic [31:0] SENSE_TAB [6] = '{32'h120, 32'h180, 32'h108, 32'h343, 32'h103, 32'h104};

	tv_cmd u_tv_cmd (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.media_ready, .mv_req, .mv_len, .mv_done, .mv_result, .mv_actual, .data_phase);
	tv_media_model u_tv_media_model (.aclk, .aresetn, .mv_req, .mv_len, .mv_done, .mv_result, .mv_actual, .fail_at,
		.fail_res, .bad_len, .lat, .n_req, .seen_len);

	initial forever #2.5 aclk = ~aclk;

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask

	task rd_reg(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Vendor bits of the last byte are random on every command
	task run(input logic [7:0] op, input logic [7:0] fl, input logic [23:0] len);
		wr(tv_pkg::ADDR_CDB_LO, {len[15:8], len[23:16], fl, op});
		wr(tv_pkg::ADDR_CDB_HI, {16'h0, 2'($random(seed)), 6'h0, len[7:0]});
		wr(tv_pkg::ADDR_CTRL, 32'h1);
		early = 1'b0;
		// Status seen done while still busy means it was posted at the start
		do begin
			rd_reg(tv_pkg::ADDR_STATUS);
			early = early | (rd[tv_pkg::STAT_BUSY_BIT] & rd[tv_pkg::STAT_DONE_BIT]);
		end while (rd[tv_pkg::STAT_BUSY_BIT] !== 1'b0);
		st = rd;
		rd_reg(tv_pkg::ADDR_COUNT);
		cnt = rd;
		rd_reg(tv_pkg::ADDR_SENSE);
		sns = rd;
		rd_reg(tv_pkg::ADDR_INFO);
		inf = rd;
	endtask

	function automatic logic [31:0] exp_info(input logic fx, input logic [23:0] len, input int kk, input int rc,
		input logic [23:0] act);
		if (fx)
			return 32'(int'(len) - kk);
		return rc == 0 ? 32'(int'(len) - int'(act)) : {8'h0, len};
	endfunction

	task wrap_up;
		$display("checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#200000;
		n_mismatch++;
		wrap_up;
	end

	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd_reg(tv_pkg::ADDR_STATUS);
		chk("status reset", 32'h0, rd);
		wr(8'h24, 32'h00000ABC);
		rd_reg(8'h20);
		chk("unmapped resp", 32'h2, 32'(rr));
		rd_reg(tv_pkg::ADDR_CFG);
		chk("cfg reset", 32'h0, rd);
		for (int i = 0; i < 2; i++) begin
			media_ready <= i[0];
			base = n_req;
			run(tv_pkg::OP_UNIT_READY, 8'h0, 24'h0);
			chk("ready check", 32'(!i[0]), 32'(st[2]));
			chk("ready sense", i ? 32'h0 : 32'h2, sns & 32'h3EF);
			chk("ready requests", base, n_req);
		end
		$display("unit ready test done");
		for (int i = 0; i < 2; i++) begin
			wr(tv_pkg::ADDR_CFG, i ? 32'h200 : 32'h0);
			run(tv_pkg::OP_VERIFY, 8'(1 - i), 24'h5);
			chk("mode check", 32'h1, 32'(st[2]));
			chk("mode sense", 32'h00810005, sns & 32'hFFFFFEFF);
		end
		wr(tv_pkg::ADDR_CFG, 32'h01000000);
		run(tv_pkg::OP_VERIFY, 8'h0, 24'h028001);
		chk("limit check", 32'h1, 32'(st[2]));
		chk("limit sense", 32'h00240005, sns & 32'hFFFFFEFF);
		media_ready <= 1'b0;
		run(tv_pkg::OP_VERIFY, 8'h0, 24'h000010);
		chk("not ready sense", 32'h2, sns & 32'h3EF);
		media_ready <= 1'b1;
		$display("mode mismatch test done");
		for (int t = 0; t < 24; t++) begin
			fixed = t[0];
			nd = t[1];
			imm = 1'($random(seed));
			r = (t / 2) % 6;
			blk = 24'({$random(seed)} % 4095 + 1);
			n = fixed ? 24'({$random(seed)} % 4 + 1) : 24'({$random(seed)} % (nd ? 32'h28000 : 32'h3C000) + 1);
			if (t >= 22)
				n = 24'h0;
			blocks = fixed ? int'(n) : int'(n != 24'h0);
			k = t < 12 ? 0 : {$random(seed)} % (blocks + 1);
			bad = fixed ? blk + 24'h1 : n ^ 24'(1 << ({$random(seed)} % 4));
			fails = k < blocks;
			wr(tv_pkg::ADDR_CFG, {7'h0, nd, fixed ? blk : 24'h0});
			fail_at <= 32'(n_req + k);
			fail_res <= 3'(r);
			bad_len <= bad;
			lat <= 32'({$random(seed)} % 4);
			base = n_req;
			run(tv_pkg::OP_VERIFY, {5'h0, imm, 1'b0, fixed}, n);
			chk("requests", fails ? k + 1 : blocks, n_req - base);
			chk("status", {blocks != 0, imm & fails, !imm & fails, 1'b1}, st[4:1]);
			chk("early status", 32'(imm && blocks != 0), 32'(early));
			chk("count", fails ? k : blocks, cnt);
			chk("sense", fails ? SENSE_TAB[r] : 32'h0, sns & 32'h3EF);
			if (fails)
				chk("info", exp_info(fixed, n, k, r, bad), inf);
			if (blocks != 0)
				chk("length", fixed ? blk : n, seen_len);
			$display("verify test %0d done", t);
		end
		wrap_up;
	end
endmodule

bind tv_cmd tv_cmd_props u_tv_cmd_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .mv_req, .mv_len,
	.mv_done, .data_phase);
